// ### design/touch_sense_pkg.sv
// shared constants and types for the touch power-state and sensing-cycle block
// assumes a 25 MHz core clock; the link clock is unrelated
package touch_sense_pkg;
   localparam int CHANNELS = 8;
   localparam int CH_W = 3;
   localparam int IDX_W = 4;
   localparam int COUNT_W = 16;
   localparam int THRESH_W = 7;
   localparam int TIMER_W = 24;
   localparam int CLOCK_MHZ = 25;
   // one step of cycle period in microseconds; code n gives (n+1) steps
   localparam int CYCLE_STEP_US = 35000;
   localparam int CYCLE_STEP_CYC = CYCLE_STEP_US * CLOCK_MHZ;
   localparam logic [CHANNELS-1:0] STATUS_RESET = 8'h00;
   localparam logic [CHANNELS-1:0] CAL_RESET = 8'h00;
   typedef enum logic [1:0] {PS_ACTIVE, PS_STANDBY, PS_COMBO, PS_DEEP} power_state_e;
endpackage : touch_sense_pkg

// ### design/cmp_if.sv
// carrier between the sequencer and the touch judge
// assumes both ends sit in the core clock domain
`timescale 1ns/1ns
`default_nettype none
interface cmp_if;
   import touch_sense_pkg::*;
   logic [COUNT_W-1:0] meas;
   logic [COUNT_W-1:0] base;
   logic [THRESH_W-1:0] thresh;
   logic touch;
   modport seq (output meas, output base, output thresh, input touch);
   modport judge (input meas, input base, input thresh, output touch);
endinterface : cmp_if
`default_nettype wire

// ### design/touch_judge.sv
// touch decision: measurement against untouched baseline and threshold
// assumes inputs are stable while the sequencer samples the result
`timescale 1ns/1ns
`default_nettype none
module touch_judge
   import touch_sense_pkg::*;
(
   cmp_if.judge cmp
);
   logic [COUNT_W-1:0] delta;
   // a count below baseline is never a touch, so the wrap of the difference is masked
   assign delta = cmp.meas - cmp.base;
   assign cmp.touch = (cmp.meas > cmp.base) && (delta > {{(COUNT_W-THRESH_W){1'b0}}, cmp.thresh});
endmodule : touch_judge
`default_nettype wire

// ### design/link_guard.sv
// link-clock side: refuses pointer-only and pointer-read transfers in deep sleep
// assumes short_xfer_i comes from protocol logic on link_clk_i
`timescale 1ns/1ns
`default_nettype none
module link_guard (
   input wire logic link_clk_i,
   input wire logic link_srst_i,
   input wire logic deep_sleep_i,
   input wire logic short_xfer_i,
   output logic short_reject_o
);
   logic deep_meta;
   logic deep_sync;

   always_ff @(posedge link_clk_i) begin
      if (link_srst_i) begin
         deep_meta <= 1'b0;
         deep_sync <= 1'b0;
      end else begin
         deep_meta <= deep_sleep_i;
         deep_sync <= deep_meta;
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (link_srst_i) begin
         short_reject_o <= 1'b0;
      end else begin
         short_reject_o <= short_xfer_i && deep_sync;
      end
   end
endmodule : link_guard
`default_nettype wire

// ### design/touch_sense_top.sv
// power-state selection and sensing-cycle sequencer for eight touch inputs
// assumes measurement logic and control bits on clock_i; bus traffic level from the link
// Behaviour
// - four power states chosen by standby, combo and deep sleep select bits
// - any power state change clears touch status bits
// - Active scans only Active-enabled inputs
// - Standby scans Standby-enabled inputs, reports touches, returns Active when cleared
// - Combo scans Active and Standby inputs, reports touches, returns Active when cleared
// - deep sleep scans nothing; bus traffic wakes device briefly, bit kept
// - only clearing deep sleep select resumes sensing; host must write it
// - Active inputs use Active settings and per-channel thresholds
// - Standby inputs use Standby settings and one shared threshold
// - Combo mixes Active and Standby settings per input in one cycle
// - Combo input enabled in both sets uses Active settings
// - Combo cycle time comes from standby cycle period field
// - Combo: gain for Active inputs, combined gain for Standby inputs
// - outside deep sleep cycles start by themselves, back to back
// - enabled inputs visited in ascending order, first to last, skipping others
// - touch declared when measurement exceeds baseline by more than threshold
// - early finish idles in low power for the rest of the cycle
// - overrun stretches the cycle and skips low-power idle
// - status readable any time; touch event pulse drives interrupt
// - deep sleep refuses pointer-only write and pointer single read
// - inputs newly enabled by a state change get calibrated
`timescale 1ns/1ns
`default_nettype none
module touch_sense_top
   import touch_sense_pkg::*;
#(
   parameter int CYCLE_STEP = CYCLE_STEP_CYC
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic link_clk_i,
   input wire logic link_srst_i,
   input wire logic standby_select_i,
   input wire logic combined_state_select_i,
   input wire logic deep_sleep_select_i,
   input wire logic [CHANNELS-1:0] active_enable_i,
   input wire logic [CHANNELS-1:0] standby_enable_i,
   input wire logic [2:0] active_sensitivity_i,
   input wire logic [2:0] standby_sensitivity_i,
   input wire logic [1:0] active_cycle_period_i,
   input wire logic [1:0] standby_cycle_period_i,
   input wire logic [1:0] gain_i,
   input wire logic [1:0] combined_gain_select_i,
   input wire logic [CHANNELS*THRESH_W-1:0] active_threshold_i,
   input wire logic [THRESH_W-1:0] standby_threshold_i,
   input wire logic [CHANNELS*COUNT_W-1:0] base_count_i,
   input wire logic [COUNT_W-1:0] meas_count_i,
   input wire logic meas_done_i,
   input wire logic bus_traffic_i,
   input wire logic short_xfer_i,
   output logic [1:0] power_state_o,
   output logic awake_o,
   output logic meas_req_o,
   output logic [CH_W-1:0] meas_ch_o,
   output logic meas_use_active_o,
   output logic [1:0] meas_gain_o,
   output logic [2:0] meas_sens_o,
   output logic [CHANNELS-1:0] touch_status_o,
   output logic touch_event_o,
   output logic idle_o,
   output logic cycle_extended_o,
   output logic [CHANNELS-1:0] calibrate_req_o,
   output logic short_reject_o
);
   typedef enum logic [2:0] {SC_HALT, SC_SELECT, SC_MEASURE, SC_IDLE} scan_state_e;

   power_state_e pstate;
   power_state_e next_pstate;
   scan_state_e scan_st;
   logic state_chg;
   logic deep_q;
   logic traffic_meta;
   logic traffic_sync;
   logic [TIMER_W-1:0] cycle_timer;
   logic [TIMER_W-1:0] cycle_target;
   logic [IDX_W-1:0] scan_idx;
   logic [CHANNELS-1:0] scan_set;
   logic next_found;
   logic [CH_W-1:0] next_ch;
   logic first_q;
   logic [CH_W-1:0] prev_ch;
   logic [CHANNELS-1:0] status_set;
   cmp_if cmp ();

   function automatic logic [CHANNELS-1:0] set_of(input power_state_e s,
         input logic [CHANNELS-1:0] act, input logic [CHANNELS-1:0] sby);
      logic [CHANNELS-1:0] r;
      r = '0;
      unique case (s)
         PS_ACTIVE: r = act;
         PS_STANDBY: r = sby;
         PS_COMBO: r = act | sby;
         PS_DEEP: r = '0;
      endcase
      return r;
   endfunction : set_of

   // deep sleep first, then combo, then standby
   always_comb begin
      if (deep_sleep_select_i) begin
         next_pstate = PS_DEEP;
      end else if (combined_state_select_i) begin
         next_pstate = PS_COMBO;
      end else if (standby_select_i) begin
         next_pstate = PS_STANDBY;
      end else begin
         next_pstate = PS_ACTIVE;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pstate <= PS_ACTIVE;
         deep_q <= 1'b0;
         state_chg <= 1'b0;
         calibrate_req_o <= CAL_RESET;
      end else if (ce_i) begin
         pstate <= next_pstate;
         deep_q <= (next_pstate == PS_DEEP);
         state_chg <= (next_pstate != pstate);
         if (next_pstate != pstate) begin
            calibrate_req_o <= set_of(next_pstate, active_enable_i, standby_enable_i)
               & ~set_of(pstate, active_enable_i, standby_enable_i);
         end else begin
            calibrate_req_o <= CAL_RESET;
         end
      end
   end

   assign power_state_o = pstate;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         traffic_meta <= 1'b0;
         traffic_sync <= 1'b0;
         awake_o <= 1'b1;
      end else if (ce_i) begin
         traffic_meta <= bus_traffic_i;
         traffic_sync <= traffic_meta;
         // the select bit is left alone; only the wake level follows the traffic
         awake_o <= (pstate != PS_DEEP) || traffic_sync;
      end
   end

   assign scan_set = set_of(pstate, active_enable_i, standby_enable_i);

   // lowest enabled input at or above the scan index
   always_comb begin
      next_found = 1'b0;
      next_ch = '0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         if (scan_set[i] && (i >= int'(scan_idx))) begin
            next_found = 1'b1;
            next_ch = CH_W'(i);
         end
      end
   end

   always_comb begin
      if (pstate == PS_ACTIVE) begin
         cycle_target = TIMER_W'(CYCLE_STEP * (int'(active_cycle_period_i) + 1));
      end else begin
         cycle_target = TIMER_W'(CYCLE_STEP * (int'(standby_cycle_period_i) + 1));
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cycle_timer <= '0;
      end else if (ce_i) begin
         if (state_chg || (scan_st == SC_HALT)) begin
            cycle_timer <= '0;
         end else if ((scan_st == SC_SELECT) && !next_found && (cycle_timer >= cycle_target)) begin
            cycle_timer <= '0;
         end else if ((scan_st == SC_IDLE) && (cycle_timer >= cycle_target - 1'b1)) begin
            cycle_timer <= '0;
         end else if (cycle_timer != '1) begin
            cycle_timer <= cycle_timer + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         scan_st <= SC_SELECT;
         scan_idx <= '0;
         meas_req_o <= 1'b0;
         meas_ch_o <= '0;
         meas_use_active_o <= 1'b1;
         meas_gain_o <= '0;
         meas_sens_o <= '0;
         idle_o <= 1'b0;
         cycle_extended_o <= 1'b0;
         first_q <= 1'b1;
         prev_ch <= '0;
      end else if (ce_i) begin
         cycle_extended_o <= 1'b0;
         if (state_chg) begin
            // a cycle under the old settings is abandoned, not finished
            meas_req_o <= 1'b0;
            idle_o <= 1'b0;
            scan_idx <= '0;
            first_q <= 1'b1;
            scan_st <= (pstate == PS_DEEP) ? SC_HALT : SC_SELECT;
         end else begin
            unique case (scan_st)
               SC_HALT: begin
                  if (pstate != PS_DEEP) begin
                     scan_st <= SC_SELECT;
                  end
               end
               SC_SELECT: begin
                  if (next_found) begin
                     meas_req_o <= 1'b1;
                     meas_ch_o <= next_ch;
                     if ((pstate == PS_ACTIVE)
                           || ((pstate == PS_COMBO) && active_enable_i[next_ch])) begin
                        meas_use_active_o <= 1'b1;
                        meas_gain_o <= gain_i;
                        meas_sens_o <= active_sensitivity_i;
                     end else begin
                        meas_use_active_o <= 1'b0;
                        meas_gain_o <= (pstate == PS_COMBO) ? combined_gain_select_i
                           : gain_i;
                        meas_sens_o <= standby_sensitivity_i;
                     end
                     scan_st <= SC_MEASURE;
                  end else if (cycle_timer < cycle_target) begin
                     idle_o <= 1'b1;
                     scan_st <= SC_IDLE;
                  end else begin
                     // overrun: new cycle at once, no idle
                     cycle_extended_o <= 1'b1;
                     scan_idx <= '0;
                     first_q <= 1'b1;
                  end
               end
               SC_MEASURE: begin
                  if (meas_done_i) begin
                     meas_req_o <= 1'b0;
                     prev_ch <= meas_ch_o;
                     first_q <= 1'b0;
                     scan_idx <= IDX_W'(meas_ch_o) + 1'b1;
                     scan_st <= SC_SELECT;
                  end
               end
               SC_IDLE: begin
                  if (cycle_timer >= cycle_target - 1'b1) begin
                     idle_o <= 1'b0;
                     scan_idx <= '0;
                     first_q <= 1'b1;
                     scan_st <= SC_SELECT;
                  end
               end
               default: begin
                  scan_st <= SC_SELECT;
               end
            endcase
         end
      end
   end

   assign cmp.meas = meas_count_i;
   assign cmp.base = base_count_i[meas_ch_o*COUNT_W +: COUNT_W];
   assign cmp.thresh = meas_use_active_o ? active_threshold_i[meas_ch_o*THRESH_W +: THRESH_W]
      : standby_threshold_i;

   touch_judge judge_u (
      .cmp(cmp)
   );

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_status
         assign status_set[g] = (scan_st == SC_MEASURE) && meas_done_i && cmp.touch
            && (meas_ch_o == CH_W'(g));
         always_ff @(posedge clock_i) begin
            if (srst_i) begin
               touch_status_o[g] <= STATUS_RESET[g];
            end else if (ce_i) begin
               if (state_chg) begin
                  touch_status_o[g] <= 1'b0;
               end else if ((scan_st == SC_MEASURE) && meas_done_i && (meas_ch_o == CH_W'(g))) begin
                  touch_status_o[g] <= cmp.touch;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         touch_event_o <= 1'b0;
      end else if (ce_i) begin
         touch_event_o <= !state_chg && |(status_set & ~touch_status_o);
      end
   end

   link_guard link_u (
      .link_clk_i(link_clk_i),
      .link_srst_i(link_srst_i),
      .deep_sleep_i(deep_q),
      .short_xfer_i(short_xfer_i),
      .short_reject_o(short_reject_o)
   );

   property p_deep_wins;
      @(posedge clock_i) disable iff (srst_i)
         (ce_i && deep_sleep_select_i) |=> (pstate == PS_DEEP);
   endproperty
   a_deep_wins: assert property (p_deep_wins) else $error("deep sleep not taken");

   property p_deep_no_scan;
      @(posedge clock_i) disable iff (srst_i)
         (pstate == PS_DEEP) [*3] |-> !meas_req_o;
   endproperty
   a_deep_no_scan: assert property (p_deep_no_scan) else $error("scan in deep sleep");

   property p_change_clears;
      @(posedge clock_i) disable iff (srst_i)
         (ce_i && state_chg) |=> (touch_status_o == '0);
   endproperty
   a_change_clears: assert property (p_change_clears) else $error("status kept");

   property p_only_enabled;
      @(posedge clock_i) disable iff (srst_i)
         (meas_req_o && !state_chg) |-> scan_set[meas_ch_o];
   endproperty
   a_only_enabled: assert property (p_only_enabled) else $error("disabled input");

   property p_ascending;
      @(posedge clock_i) disable iff (srst_i)
         $rose(meas_req_o) && !first_q |-> (meas_ch_o > prev_ch);
   endproperty
   a_ascending: assert property (p_ascending) else $error("order broken");

   property p_both_uses_active;
      @(posedge clock_i) disable iff (srst_i)
         $rose(meas_req_o) && (pstate == PS_COMBO) && active_enable_i[meas_ch_o]
            && $stable(active_enable_i) |-> meas_use_active_o && (meas_gain_o == $past(gain_i));
   endproperty
   a_both_uses_active: assert property (p_both_uses_active) else $error("combo settings");

   property p_combo_gain;
      @(posedge clock_i) disable iff (srst_i)
         $rose(meas_req_o) && !meas_use_active_o && ($past(pstate) == PS_COMBO)
            |-> (meas_gain_o == $past(combined_gain_select_i));
   endproperty
   a_combo_gain: assert property (p_combo_gain) else $error("combo gain");

   property p_idle_early;
      @(posedge clock_i) disable iff (srst_i)
         $rose(idle_o) |-> ($past(cycle_timer) < $past(cycle_target)) && !cycle_extended_o;
   endproperty
   a_idle_early: assert property (p_idle_early) else $error("idle after overrun");

   property p_restart;
      @(posedge clock_i) disable iff (srst_i)
         (ce_i && cycle_extended_o) |-> (scan_st == SC_SELECT) && (cycle_timer <= 1);
   endproperty
   a_restart: assert property (p_restart) else $error("no back to back cycle");
endmodule : touch_sense_top
`default_nettype wire

// ### testbench/touch_front.sv
// measurement front end model: answers each scan request with a count
// assumes requests and channel come from the sequencer on clock_i
`timescale 1ns/1ns
`default_nettype none
module touch_front
   import touch_sense_pkg::*;
(
   input wire logic clock_i,
   input wire logic meas_req_i,
   input wire logic [CH_W-1:0] meas_ch_i,
   input wire logic slow_i,
   input wire logic [CHANNELS*COUNT_W-1:0] base_i,
   input wire logic [CHANNELS*COUNT_W-1:0] delta_i,
   output logic meas_done_o,
   output logic [COUNT_W-1:0] meas_count_o
);
   int wait_n = 0;
   logic busy = 1'b0;
   initial begin
      meas_done_o = 1'b0;
      meas_count_o = 16'h0000;
   end
   // count = baseline + delta; outside the done pulse the count is scrambled
   always @(posedge clock_i) begin
      #2;
      if (meas_done_o) begin
         meas_done_o = 1'b0;
         meas_count_o = ~meas_count_o;
         busy = 1'b0;
      end else if (busy) begin
         if (!meas_req_i) begin
            busy = 1'b0;
         end else if (wait_n == 0) begin
            meas_done_o = 1'b1;
            meas_count_o = base_i[meas_ch_i*16+:16] + delta_i[meas_ch_i*16+:16];
         end else begin
            wait_n--;
         end
      end else if (meas_req_i) begin
         busy = 1'b1;
         wait_n = slow_i ? 6 : $urandom_range(2, 0);
      end
   end
endmodule : touch_front
`default_nettype wire

// ### testbench/touch_power_state_sensing_cycle_bench.sv
// self-checking bench: power states, scan order, per-input settings, touches, cycle timing
// assumes the front end model and a link clock that runs only during reset and inside frames
`timescale 1ns/1ns
`default_nettype none
module touch_power_state_sensing_cycle_bench;
   import touch_sense_pkg::*;
   localparam int STEP = 40;
   logic clock_i = 0, srst_i = 1, link_clk_i = 0, link_srst_i = 1, link_on = 1;
   logic sby_sel = 0, cmb_sel = 0, dsl_sel = 0, traffic = 0, short_x = 0, slow = 0, ce = 1;
   logic [7:0] act = 0, sby = 0, status, cal, mstatus = 0;
   logic [2:0] asens = 0, ssens = 0, ch, sens;
   logic [1:0] aper = 0, sper = 0, gain = 0, cgain = 0, ps, mgain, prev_ps = 0;
   logic [55:0] athr = 0;
   logic [6:0] sthr = 0;
   logic [127:0] base = 0, delta = 0;
   logic [15:0] count;
   logic done, awake, req, use_act, ev, idle, ext, rej, prev_req = 0, last_ua = 0;
   int fail_count = 0, n_compared = 0, cyc = 0, idle_cnt = 0, ext_cnt = 0, rej_cnt = 0;
   int last_ch = -1, skip = 0, period = 0, first_t = 0, seed_v;

   always #20 clock_i = ~clock_i;
   initial begin
      #7;
      forever #40 if (link_on || link_clk_i) link_clk_i = ~link_clk_i;
   end

   touch_sense_top #(.CYCLE_STEP(STEP)) touch_sense_top_i (.clock_i(clock_i), .srst_i(srst_i),
      .ce_i(ce), .link_clk_i(link_clk_i), .link_srst_i(link_srst_i),
      .standby_select_i(sby_sel), .combined_state_select_i(cmb_sel),
      .deep_sleep_select_i(dsl_sel), .active_enable_i(act), .standby_enable_i(sby),
      .active_sensitivity_i(asens), .standby_sensitivity_i(ssens),
      .active_cycle_period_i(aper), .standby_cycle_period_i(sper), .gain_i(gain),
      .combined_gain_select_i(cgain), .active_threshold_i(athr), .standby_threshold_i(sthr),
      .base_count_i(base), .meas_count_i(count), .meas_done_i(done),
      .bus_traffic_i(traffic), .short_xfer_i(short_x), .power_state_o(ps), .awake_o(awake),
      .meas_req_o(req), .meas_ch_o(ch), .meas_use_active_o(use_act), .meas_gain_o(mgain),
      .meas_sens_o(sens), .touch_status_o(status), .touch_event_o(ev), .idle_o(idle),
      .cycle_extended_o(ext), .calibrate_req_o(cal), .short_reject_o(rej));
   touch_front touch_front_i (.clock_i(clock_i), .meas_req_i(req), .meas_ch_i(ch),
      .slow_i(slow), .base_i(base), .delta_i(delta), .meas_done_o(done),
      .meas_count_o(count));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   function automatic logic [7:0] en_set(input logic [1:0] s);
      case (s)
         2'd0: return act;
         2'd1: return sby;
         2'd2: return act | sby;
         default: return 8'h00;
      endcase
   endfunction : en_set

   function automatic int next_ch(input logic [7:0] set, input int last);
      for (int i = last + 1; i < 8; i++) if (set[i]) return i;
      for (int i = 0; i < 8; i++) if (set[i]) return i;
      return -1;
   endfunction : next_ch

   task automatic check_req();
      int e;
      e = next_ch(en_set(ps), last_ch);
      if (e < 0) begin
         check("req_without_input", req, 1'b0);
         return;
      end
      last_ua = (ps == 2'd0) || (ps == 2'd2 && act[e]);
      check("meas_ch", ch, e);
      check("use_active", use_act, last_ua);
      check("gain", mgain, (ps == 2'd2 && !last_ua) ? cgain : gain);
      check("sens", sens, last_ua ? asens : ssens);
      if (e <= last_ch || last_ch < 0) begin
         if (first_t > 0) period = cyc - first_t;
         first_t = cyc;
      end
      last_ch = e;
   endtask : check_req

   task automatic check_result();
      logic [15:0] b;
      logic [6:0] t;
      logic hit;
      if (last_ch < 0) return;
      b = base[last_ch*16+:16];
      t = last_ua ? athr[last_ch*7+:7] : sthr;
      hit = (count > b) && ((count - b) > {9'h000, t});
      check("touch_event", ev, hit && !mstatus[last_ch]);
      mstatus[last_ch] = hit;
      check("touch_status", status, mstatus);
   endtask : check_result

   always @(posedge clock_i) begin
      #1;
      cyc++;
      if (idle === 1'b1) idle_cnt++;
      if (ext === 1'b1) ext_cnt++;
      if (ps !== prev_ps) begin
         check("calibrate_req", cal, en_set(ps) & ~en_set(prev_ps));
         mstatus = 8'h00;
         last_ch = -1;
         first_t = 0;
         skip = 1;
      end else begin
         if (skip > 0) begin
            skip = 0;
            check("status_cleared", status, 8'h00);
         end else if (done === 1'b1 && prev_req === 1'b1) check_result();
         if (req === 1'b1 && prev_req === 1'b0) check_req();
      end
      prev_ps = ps;
      prev_req = req;
   end
   always @(posedge link_clk_i) if (rej === 1'b1) rej_cnt++;

   // enable sets and settings change only in deep sleep, so no scan runs on stale sets
   task automatic set_state(input logic [2:0] bits, input logic [7:0] a, input logic [7:0] s);
      @(posedge clock_i);
      #2 dsl_sel = 1'b1;
      repeat (4) @(posedge clock_i);
      #2 act = a;
      sby = s;
      {asens, ssens, gain, cgain, sthr} = $urandom;
      for (int i = 0; i < 8; i++) begin
         athr[i*7+:7] = $urandom;
         base[i*16+:16] = 16'h1000 + $urandom_range(16'h3000);
         delta[i*16+:16] = $urandom_range(200);
      end
      {dsl_sel, cmb_sel, sby_sel} = bits;
      repeat (3) @(posedge clock_i);
   endtask : set_state

   task automatic link_frame(input int exp_rej);
      rej_cnt = 0;
      link_on = 1'b1;
      repeat (3) @(posedge link_clk_i);
      #2 short_x = 1'b1;
      @(posedge link_clk_i);
      #2 short_x = 1'b0;
      repeat (4) @(posedge link_clk_i);
      link_on = 1'b0;
      check("short_reject", rej_cnt > 0, exp_rej);
   endtask : link_frame

   initial begin
      #3000000;
      fail_count++;
      report_and_stop();
   end

   initial begin
      seed_v = $urandom(8202);
      repeat (8) @(posedge clock_i);
      #2 srst_i = 1'b0;
      link_srst_i = 1'b0;
      link_on = 1'b0;
      for (int k = 0; k < 16; k++) begin
         set_state(k[2:0], $urandom, $urandom);
         repeat (300) @(posedge clock_i);
         check("power_state", ps, k[2] ? 3 : k[1] ? 2 : k[0] ? 1 : 0);
         #2 {dsl_sel, cmb_sel, sby_sel} = 3'b000;
         repeat (100) @(posedge clock_i);
         check("back_to_active", ps, 2'd0);
      end
      $display("test power_states done");
      for (int st = 0; st < 3; st++) begin
         for (int code = 0; code < 4; code++) begin
            aper = st == 0 ? code : 3 - code;
            sper = st == 0 ? 3 - code : code;
            seed_v = 1 << $urandom_range(7);
            set_state(st == 2 ? 3'b010 : st[2:0], seed_v, seed_v);
            repeat ((code + 1) * STEP) @(posedge clock_i);
            period = 0;
            idle_cnt = 0;
            ext_cnt = 0;
            repeat (2 * (code + 1) * STEP + 10) @(posedge clock_i);
            check("cycle_period", period, (code + 1) * STEP);
            check("idle_seen", idle_cnt > 0, 1);
            check("no_extend", ext_cnt, 0);
         end
      end
      $display("test cycle_time done");
      slow = 1'b1;
      aper = 2'd0;
      set_state(3'b000, 8'hFF, 8'h00);
      repeat (100) @(posedge clock_i);
      idle_cnt = 0;
      ext_cnt = 0;
      repeat (200) @(posedge clock_i);
      check("extended", ext_cnt > 0, 1);
      check("no_idle", idle_cnt, 0);
      slow = 1'b0;
      $display("test overrun done");
      set_state(3'b100, 8'hFF, 8'hFF);
      #2 traffic = 1'b1;
      repeat (6) @(posedge clock_i);
      check("awake", awake, 1'b1);
      check("still_deep", ps, 2'd3);
      link_frame(1);
      #2 traffic = 1'b0;
      repeat (6) @(posedge clock_i);
      check("asleep", awake, 1'b0);
      // clock enable low freezes the state even though the select bit is cleared
      #2 ce = 1'b0;
      dsl_sel = 1'b0; // host clears the bit to resume sensing
      repeat (5) @(posedge clock_i);
      check("frozen", ps, 2'd3);
      #2 ce = 1'b1;
      repeat (50) @(posedge clock_i);
      check("resumed", ps, 2'd0);
      link_frame(0);
      $display("test deep_sleep done");
      report_and_stop();
   end
endmodule : touch_power_state_sensing_cycle_bench
`default_nettype wire
